// file: csic_pkg.sv
// constants and register map of the clock status interrupt controller
package csic_pkg;
   // pin function codes
   localparam logic [7:0] FN_MAIN_CLOCK_ON   = 8'h4B;
   localparam logic [7:0] FN_SECOND_CLOCK_ON = 8'h4C;
   localparam logic [7:0] FN_MAIN_TOO_SLOW   = 8'h0A;
   localparam logic [7:0] FN_SECOND_TOO_SLOW = 8'h0B;
   localparam logic [7:0] FN_MIX_DROP        = 8'h27;
   localparam logic [7:0] FN_PORT1_ERR       = 8'h28;
   localparam logic [7:0] FN_PORT2_ERR       = 8'h29;
   localparam logic [7:0] FN_PORT3_ERR       = 8'h2A;
   localparam logic [7:0] FN_TOO_SLOW        = 8'h2D;
   localparam logic [7:0] FN_OVER_LIMIT      = 8'h2E;
   localparam logic [7:0] FN_REQ_A           = 8'h01;
   localparam logic [7:0] FN_REQ_B           = 8'h02;
   // register byte offsets
   localparam logic [11:0] OFS_CTRL     = 12'h000;
   localparam logic [11:0] OFS_FLAG_A   = 12'h004;
   localparam logic [11:0] OFS_FLAG_B   = 12'h008;
   localparam logic [11:0] OFS_MASK_A   = 12'h00C;
   localparam logic [11:0] OFS_MASK_B   = 12'h010;
   localparam logic [11:0] OFS_RAW      = 12'h014;
   localparam logic [11:0] OFS_SUBSYS   = 12'h018;
   localparam logic [11:0] OFS_PINFN    = 12'h01C;
   localparam logic [11:0] OFS_DEBOUNCE = 12'h020;
   localparam logic [11:0] OFS_REQSTATE = 12'h024;
   // control register fields
   localparam int CTRL_MAIN_ON    = 0;
   localparam int CTRL_SECOND_ON  = 1;
   localparam int CTRL_GMASK_A    = 2;
   localparam int CTRL_GMASK_B    = 3;
   localparam int CTRL_POLARITY   = 10;
   localparam logic [31:0] CTRL_RESET = 32'h0000040C;
   // source indices
   localparam int NSRC          = 14;
   localparam int SRC_MAIN_OFF  = 0;
   localparam int SRC_SEC_OFF   = 1;
   localparam int SRC_MAIN_SLOW = 2;
   localparam int SRC_SEC_SLOW  = 3;
   localparam int SRC_MIX_DROP  = 4;
   localparam int SRC_TOO_SLOW  = 5;
   localparam int SRC_OVER      = 6;
   localparam int SRC_PORT1     = 7;
   localparam int SRC_PORT2     = 8;
   localparam int SRC_PORT3     = 9;
   localparam int SRC_JACK_RISE = 10;
   localparam int SRC_JACK_FALL = 11;
   localparam int SRC_GP5_RISE  = 12;
   localparam int SRC_GP5_FALL  = 13;
   // sources whose flag sets on either edge; others rising only
   localparam logic [NSRC-1:0] BOTH_EDGE = 14'h03FC;
   localparam logic [NSRC-1:0] MASK_RESET = 14'h3FFF;
   localparam logic [7:0] DEBOUNCE_CYCLES = 8'h10;
endpackage

// file: csic_ctrl.sv
// clock status interrupt controller with APB register access
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module csic_ctrl
   import csic_pkg::*;
#(
   parameter int NPINS = 5
) (
   input  wire logic              SYS_CLK,
   input  wire logic              SYS_RST,
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [11:0]       PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic      [31:0]       PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   input  wire logic              MAIN_SHUTDOWN_DONE,
   input  wire logic              SECOND_SHUTDOWN_DONE,
   input  wire logic              MAIN_TOO_SLOW,
   input  wire logic              SECOND_TOO_SLOW,
   input  wire logic              MIX_DROP,
   input  wire logic [4:0]        SUBSYS_TOO_SLOW,
   input  wire logic [2:0]        SUBSYS_OVER_LIMIT,
   input  wire logic [2:0]        PORT_CONFIG_ERR,
   input  wire logic              JACK_SENSE_ONE,
   input  wire logic [NPINS-1:0]  GENERAL_PIN_IN,
   input  wire logic              PATH_ENABLE_REQ,
   output logic                   PATH_ENABLE_GRANT,
   output logic                   MAIN_CLOCK_ON,
   output logic                   SECOND_CLOCK_ON,
   output logic [NPINS-1:0]       PIN_OUT,
   output logic                   REQUEST_OUT_A,
   output logic                   REQUEST_OUT_B
);

   typedef struct packed {
      logic [31:0]           ctrl;
      logic [NSRC-1:0]       flag_a;
      logic [NSRC-1:0]       flag_b;
      logic [NSRC-1:0]       mask_a;
      logic [NSRC-1:0]       mask_b;
      logic [8*NPINS-1:0]    pinfn;
      logic [NPINS-1:0]      deb_en;
      logic [9:0]            sync1;
      logic [9:0]            sync2;
      logic [NPINS:0]        psync1;
      logic [NPINS:0]        psync2;
      logic [NPINS:0]        pstable;
      logic [8*(NPINS+1)-1:0] pcnt;
      logic [NSRC-1:0]       raw_prev;
      logic                  path_on;
      logic [31:0]           rdata;
      logic [NPINS-1:0]      pin_out;
      logic                  req_a;
      logic                  req_b;
   } csic_state_t;

   csic_state_t state_reg;
   csic_state_t state_next;

   logic [NSRC-1:0] raw;
   logic [NSRC-1:0] edge_hit;
   logic [9:0]      sync_in;
   logic            too_slow_status;
   logic            over_limit_status;
   logic            wr_en;
   logic            rd_en;
   logic            addr_ok;
   logic [8:0]      pin_level_readback;
   logic            jack_lvl;
   logic            gp5_lvl;

   assign too_slow_status   = |SUBSYS_TOO_SLOW;
   assign over_limit_status = |SUBSYS_OVER_LIMIT;
   // bit order follows the source indices so raw[] lines up with the flag bits
   assign sync_in = {PORT_CONFIG_ERR, over_limit_status, too_slow_status, MIX_DROP,
                     SECOND_TOO_SLOW, MAIN_TOO_SLOW, SECOND_SHUTDOWN_DONE, MAIN_SHUTDOWN_DONE};
   assign jack_lvl = state_reg.pstable[NPINS];
   assign gp5_lvl  = state_reg.pstable[NPINS-1];
   assign pin_level_readback = 9'(state_reg.pstable);

   // raw levels, in source order
   assign raw = {~gp5_lvl, gp5_lvl, ~jack_lvl, jack_lvl,
                 state_reg.sync2[9:7], state_reg.sync2[6:5], state_reg.sync2[4:0]};

   // edge detection against the registered copy keeps each set to one cycle
   genvar gi;
   generate
      for (gi = 0; gi < NSRC; gi++) begin : g_edge
         if (BOTH_EDGE[gi]) begin : g_both
            assign edge_hit[gi] = raw[gi] ^ state_reg.raw_prev[gi];
         end else begin : g_rise
            assign edge_hit[gi] = raw[gi] & ~state_reg.raw_prev[gi];
         end
      end
   endgenerate

   assign addr_ok = (PADDR[1:0] == 2'h0) && (PADDR <= OFS_REQSTATE);
   assign wr_en   = PSEL && PENABLE && PWRITE && addr_ok;
   assign rd_en   = PSEL && !PENABLE && !PWRITE;

   function automatic logic pin_sel(input logic [7:0] fn, input logic [NSRC-1:0] r,
                                    input logic [31:0] c, input logic ra, input logic rb);
      logic v;
      v = 1'b0;
      unique case (fn)
         FN_MAIN_CLOCK_ON:   v = c[CTRL_MAIN_ON];
         FN_SECOND_CLOCK_ON: v = c[CTRL_SECOND_ON];
         FN_MAIN_TOO_SLOW:   v = r[SRC_MAIN_SLOW];
         FN_SECOND_TOO_SLOW: v = r[SRC_SEC_SLOW];
         FN_MIX_DROP:        v = r[SRC_MIX_DROP];
         FN_TOO_SLOW:        v = r[SRC_TOO_SLOW];
         FN_OVER_LIMIT:      v = r[SRC_OVER];
         FN_PORT1_ERR:       v = r[SRC_PORT1];
         FN_PORT2_ERR:       v = r[SRC_PORT2];
         FN_PORT3_ERR:       v = r[SRC_PORT3];
         FN_REQ_A:           v = ra;
         FN_REQ_B:           v = rb;
         default:            v = 1'b0;
      endcase
      return v;
   endfunction

   always_comb begin
      logic [NSRC-1:0] clr_a;
      logic [NSRC-1:0] clr_b;
      logic [NPINS:0]  pin_raw;
      clr_a = '0;
      clr_b = '0;
      pin_raw = '0;
      state_next = state_reg;
      state_next.sync1 = sync_in;
      state_next.sync2 = state_reg.sync1;
      pin_raw = {JACK_SENSE_ONE, GENERAL_PIN_IN};
      state_next.psync1 = pin_raw;
      state_next.psync2 = state_reg.psync1;
      // debounce: a pin level with deb_en set is taken only after it holds steady; jack always filtered
      for (int i = 0; i <= NPINS; i++) begin
         if (i < NPINS && !state_reg.deb_en[i]) begin
            state_next.pstable[i] = state_reg.psync2[i];
            state_next.pcnt[8*i +: 8] = 8'h00;
         end else if (state_reg.psync2[i] == state_reg.pstable[i]) begin
            state_next.pcnt[8*i +: 8] = 8'h00;
         end else if (state_reg.pcnt[8*i +: 8] == DEBOUNCE_CYCLES) begin
            state_next.pstable[i] = state_reg.psync2[i];
            state_next.pcnt[8*i +: 8] = 8'h00;
         end else begin
            state_next.pcnt[8*i +: 8] = state_reg.pcnt[8*i +: 8] + 8'h01;
         end
      end
      state_next.raw_prev = raw;
      if (wr_en && PADDR == OFS_FLAG_A) clr_a = PWDATA[NSRC-1:0];
      if (wr_en && PADDR == OFS_FLAG_B) clr_b = PWDATA[NSRC-1:0];
      // a set in the clearing cycle wins
      state_next.flag_a = (state_reg.flag_a & ~clr_a) | (edge_hit & ~state_reg.mask_a);
      state_next.flag_b = (state_reg.flag_b & ~clr_b) | (edge_hit & ~state_reg.mask_b);
      if (wr_en) begin
         unique case (PADDR)
            OFS_CTRL:     state_next.ctrl = {21'h0, PWDATA[CTRL_POLARITY], 6'h0, PWDATA[3:0]};
            OFS_MASK_A:   state_next.mask_a = PWDATA[NSRC-1:0];
            OFS_MASK_B:   state_next.mask_b = PWDATA[NSRC-1:0];
            OFS_PINFN:    state_next.pinfn = PWDATA[8*NPINS-1:0];
            OFS_DEBOUNCE: state_next.deb_en = PWDATA[NPINS-1:0];
            default:      state_next.ctrl = state_reg.ctrl;
         endcase
      end
      // a new path is only granted while the main clock is on and raw too-slow and over-limit are low; running paths stay
      if (!PATH_ENABLE_REQ) begin
         state_next.path_on = 1'b0;
      end else if (!state_reg.path_on && !raw[SRC_TOO_SLOW] && !raw[SRC_OVER] &&
                   state_reg.ctrl[CTRL_MAIN_ON]) begin
         state_next.path_on = 1'b1;
      end
      state_next.req_a = |state_reg.flag_a & ~state_reg.ctrl[CTRL_GMASK_A];
      state_next.req_b = |state_reg.flag_b & ~state_reg.ctrl[CTRL_GMASK_B];
      for (int p = 0; p < NPINS; p++) begin
         state_next.pin_out[p] = pin_sel(state_reg.pinfn[8*p +: 8], raw, state_reg.ctrl,
                                         state_reg.req_a, state_reg.req_b);
      end
      if (rd_en) begin
         unique case (PADDR)
            OFS_CTRL:     state_next.rdata = state_reg.ctrl;
            OFS_FLAG_A:   state_next.rdata = 32'(state_reg.flag_a);
            OFS_FLAG_B:   state_next.rdata = 32'(state_reg.flag_b);
            OFS_MASK_A:   state_next.rdata = 32'(state_reg.mask_a);
            OFS_MASK_B:   state_next.rdata = 32'(state_reg.mask_b);
            OFS_RAW:      state_next.rdata = {9'h0, pin_level_readback, raw};
            OFS_SUBSYS:   state_next.rdata = {24'h0, SUBSYS_OVER_LIMIT, SUBSYS_TOO_SLOW};
            OFS_PINFN:    state_next.rdata = 32'(state_reg.pinfn);
            OFS_DEBOUNCE: state_next.rdata = 32'(state_reg.deb_en);
            OFS_REQSTATE: state_next.rdata = {30'h0, state_reg.req_b, state_reg.req_a};
            default:      state_next.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state_reg <= '0;
         state_reg.ctrl <= CTRL_RESET;
         state_reg.mask_a <= MASK_RESET;
         state_reg.mask_b <= MASK_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign PRDATA            = state_reg.rdata;
   assign PREADY            = 1'b1;
   assign PSLVERR           = PSEL && PENABLE && !addr_ok;
   assign MAIN_CLOCK_ON     = state_reg.ctrl[CTRL_MAIN_ON];
   assign SECOND_CLOCK_ON   = state_reg.ctrl[CTRL_SECOND_ON];
   assign PIN_OUT           = state_reg.pin_out;
   assign PATH_ENABLE_GRANT = state_reg.path_on;
   assign REQUEST_OUT_A     = state_reg.req_a ^ state_reg.ctrl[CTRL_POLARITY];
   assign REQUEST_OUT_B     = state_reg.req_b;

   AST_FLAG_HOLD: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      state_reg.flag_a[0] && !(wr_en && PADDR == OFS_FLAG_A && PWDATA[0]) |=> state_reg.flag_a[0])
      else $error("flag a dropped without clear");
   AST_MASKED_NOSET: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      !state_reg.flag_b[SRC_OVER] && state_reg.mask_b[SRC_OVER] |=> !state_reg.flag_b[SRC_OVER])
      else $error("masked source set flag");
   AST_EDGE_SET: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      $fell(raw[SRC_PORT1]) && !state_reg.mask_a[SRC_PORT1] |=> state_reg.flag_a[SRC_PORT1])
      else $error("falling port error not flagged");
   AST_RISE_ONLY: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      $fell(raw[SRC_MAIN_OFF]) && !state_reg.flag_a[SRC_MAIN_OFF] && !state_reg.mask_a[SRC_MAIN_OFF] |=>
      !state_reg.flag_a[SRC_MAIN_OFF])
      else $error("shutdown flag set on fall");
   AST_REQ_OR: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (|state_reg.flag_a) && !state_reg.ctrl[CTRL_GMASK_A] |=> state_reg.req_a)
      else $error("request a missing");
   AST_REQ_CLEAR: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      state_reg.flag_b == '0 |=> !state_reg.req_b)
      else $error("request b without flag");
   AST_POLARITY: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      REQUEST_OUT_A == (state_reg.req_a ^ state_reg.ctrl[CTRL_POLARITY]))
      else $error("request a polarity wrong");
   AST_NO_GRANT_SLOW: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      !state_reg.path_on && raw[SRC_TOO_SLOW] |=> !state_reg.path_on)
      else $error("path granted while too slow");
   AST_SUBSYS_OR: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (SUBSYS_TOO_SLOW != 5'h00) |-> ##2 state_reg.sync2[SRC_TOO_SLOW] || $changed(SUBSYS_TOO_SLOW)
      || $past(SUBSYS_TOO_SLOW) == 5'h00)
      else $error("combined too-slow lost");

endmodule // csic_ctrl

// file: csic_host_model.sv
// host processor model: apb master that reads, clears and masks the interrupt flags
`timescale 1ns/1ps
module csic_host_model
   import csic_pkg::*;
(
   input  wire logic        clk,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic [1:0]  shutdown_done,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata
);
   logic [1:0] clock_on_shadow;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      clock_on_shadow = 2'h0;
   end
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines must not keep showing the last value
      paddr <= ~a;
      pwdata <= ~d;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      int          n;
      apb(1'b1, a, d, r, e);
      if (a === OFS_CTRL) begin
         for (int i = 0; i < 2; i++) begin
            // no further writes until the switched-off clock has shut down or 200 cycles have passed
            if (clock_on_shadow[i] && !d[i]) begin
               n = 0;
               while (shutdown_done[i] !== 1'b1 && n < 200) begin
                  @(posedge clk);
                  n++;
               end
            end
         end
         clock_on_shadow = d[1:0];
      end
   endtask
   task automatic clear(input logic [11:0] a, input logic [31:0] bits);
      wr(a, bits);
   endtask
endmodule // csic_host_model

// file: csic_tb.sv
// self-checking testbench of the clock status interrupt controller
`timescale 1ns/1ps
module tb
   import csic_pkg::*;
;
   logic        SYS_CLK = 1'b0, SYS_RST = 1'b1;
   logic        PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, PRDATA;
   logic [1:0]  DONE = 2'h0;
   logic        MAIN_TOO_SLOW = 0, SECOND_TOO_SLOW = 0, MIX_DROP = 0, JACK = 0, PATH_REQ = 0;
   logic [4:0]  SUB_SLOW = 5'h00, GP = 5'h00, PIN_OUT;
   logic [2:0]  SUB_OVER = 3'h0, PORT_ERR = 3'h0;
   logic        GRANT, MAIN_ON, SECOND_ON, REQ_A, REQ_B, ERR;
   logic [31:0] RD;
   logic [7:0]  codes [2:9] = '{8'h0A, 8'h0B, 8'h27, 8'h2D, 8'h2E, 8'h28, 8'h29, 8'h2A};
   int          bad_count = 0, check_count = 0;
   always #2 SYS_CLK = ~SYS_CLK;
   csic_host_model csic_host_model_inst (.clk(SYS_CLK), .prdata(PRDATA), .pready(PREADY), .pslverr(PSLVERR),
      .shutdown_done(DONE), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE), .paddr(PADDR), .pwdata(PWDATA));
   csic_ctrl csic_ctrl_inst (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .MAIN_SHUTDOWN_DONE(DONE[0]), .SECOND_SHUTDOWN_DONE(DONE[1]), .MAIN_TOO_SLOW(MAIN_TOO_SLOW),
      .SECOND_TOO_SLOW(SECOND_TOO_SLOW), .MIX_DROP(MIX_DROP), .SUBSYS_TOO_SLOW(SUB_SLOW),
      .SUBSYS_OVER_LIMIT(SUB_OVER), .PORT_CONFIG_ERR(PORT_ERR), .JACK_SENSE_ONE(JACK), .GENERAL_PIN_IN(GP),
      .PATH_ENABLE_REQ(PATH_REQ), .PATH_ENABLE_GRANT(GRANT), .MAIN_CLOCK_ON(MAIN_ON),
      .SECOND_CLOCK_ON(SECOND_ON), .PIN_OUT(PIN_OUT), .REQUEST_OUT_A(REQ_A), .REQUEST_OUT_B(REQ_B));
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp, input string n);
      csic_host_model_inst.apb(1'b0, a, 32'h00000000, RD, ERR);
      check(n, RD & m, exp);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge SYS_CLK);
   endtask
   task automatic set_src(input int i, input logic v);
      case (i)
         2: MAIN_TOO_SLOW <= v;
         3: SECOND_TOO_SLOW <= v;
         4: MIX_DROP <= v;
         5: SUB_SLOW <= {v, 4'h0};
         6: SUB_OVER <= {1'b0, v, 1'b0};
         default: PORT_ERR <= 3'({2'b00, v} << (i - 7));
      endcase
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      settle(20000);
      bad_count++;
      complete_run;
   end
   initial begin
      settle(3);
      SYS_RST <= 1'b0;
      rdc(OFS_CTRL, 32'hFFFFFFFF, CTRL_RESET, "ctrl reset");
      rdc(OFS_MASK_A, 32'hFFFFFFFF, 32'h00003FFF, "mask a reset");
      rdc(OFS_REQSTATE, 32'hFFFFFFFF, 32'h00000000, "request state reset");
      check("request a idle", REQ_A, 1'b1);
      check("request b idle", REQ_B, 1'b0);
      rdc(12'h100, 32'hFFFFFFFF, 32'h00000000, "unmapped read");
      check("unmapped error", ERR, 1'b1);
      csic_host_model_inst.wr(OFS_CTRL, 32'h00000401);
      csic_host_model_inst.wr(OFS_MASK_A, 32'h00000000);
      PATH_REQ <= 1'b1;
      settle(10);
      check("grant with clock on", GRANT, 1'b1);
      for (int i = 2; i < 10; i++) begin
         csic_host_model_inst.wr(OFS_PINFN, {24'h000000, codes[i]});
         set_src(i, 1'b1);
         settle(10);
         rdc(OFS_FLAG_A, 32'hFFFFFFFF, 32'h1 << i, "flag a rise");
         rdc(OFS_FLAG_B, 32'hFFFFFFFF, 32'h0, "flag b masked");
         rdc(OFS_RAW, 32'h1 << i, 32'h1 << i, "raw level");
         rdc(OFS_SUBSYS, 32'hFF, (i == 5) ? 32'h10 : (i == 6) ? 32'h40 : 32'h0, "subsystem");
         check("pin function high", PIN_OUT[0], 1'b1);
         check("request a asserted", REQ_A, 1'b0);
         if (i == 5 || i == 6) begin
            check("running path kept", GRANT, 1'b1);
            PATH_REQ <= 1'b0;
            settle(2);
            PATH_REQ <= 1'b1;
            settle(3);
            check("grant refused", GRANT, 1'b0);
         end
         csic_host_model_inst.wr(OFS_FLAG_A, 32'h0);
         rdc(OFS_FLAG_A, 32'hFFFFFFFF, 32'h1 << i, "flag kept on zero");
         csic_host_model_inst.clear(OFS_FLAG_A, 32'h1 << i);
         rdc(OFS_FLAG_A, 32'hFFFFFFFF, 32'h0, "flag cleared");
         check("request a released", REQ_A, 1'b1);
         set_src(i, 1'b0);
         settle(10);
         rdc(OFS_FLAG_A, 32'hFFFFFFFF, 32'h1 << i, "flag a fall");
         check("pin function low", PIN_OUT[0], 1'b0);
         csic_host_model_inst.clear(OFS_FLAG_A, 32'h3FFF);
      end
      for (int j = 0; j < 2; j++) begin
         csic_host_model_inst.wr(OFS_PINFN, {24'h000000, FN_MAIN_CLOCK_ON + 8'(j)});
         csic_host_model_inst.wr(OFS_CTRL, 32'h00000400 | (32'h1 << j));
         settle(3);
         check("clock on outputs", {SECOND_ON, MAIN_ON}, 2'h1 << j);
         check("clock on pin", PIN_OUT[0], 1'b1);
         fork
            csic_host_model_inst.wr(OFS_CTRL, 32'h00000400);
            begin
               settle(6);
               DONE[j] <= 1'b1;
            end
         join
         settle(10);
         rdc(OFS_FLAG_A, 32'hFFFFFFFF, 32'h1 << j, "shutdown flag");
         PATH_REQ <= 1'b0;
         settle(2);
         PATH_REQ <= 1'b1;
         settle(3);
         check("grant without clock", GRANT, 1'b0);
         csic_host_model_inst.clear(OFS_FLAG_A, 32'h3FFF);
         DONE[j] <= 1'b0;
         settle(10);
         rdc(OFS_FLAG_A, 32'hFFFFFFFF, 32'h0, "no flag on fall");
      end
      JACK <= 1'b1;
      settle(40);
      rdc(OFS_FLAG_A, 32'hFFFFFFFF, 32'h1 << SRC_JACK_RISE, "jack rise");
      csic_host_model_inst.clear(OFS_FLAG_A, 32'h3FFF);
      JACK <= 1'b0;
      settle(40);
      rdc(OFS_FLAG_A, 32'hFFFFFFFF, 32'h1 << SRC_JACK_FALL, "jack fall");
      csic_host_model_inst.clear(OFS_FLAG_A, 32'h3FFF);
      csic_host_model_inst.wr(OFS_DEBOUNCE, 32'h00000010);
      GP <= 5'h10;
      settle(5);
      GP <= 5'h00;
      settle(40);
      rdc(OFS_FLAG_A, 32'hFFFFFFFF, 32'h0, "glitch filtered");
      GP <= 5'h10;
      settle(40);
      rdc(OFS_FLAG_A, 32'hFFFFFFFF, 32'h1 << SRC_GP5_RISE, "pin five rise");
      GP <= 5'h00;
      settle(40);
      rdc(OFS_FLAG_A, 32'hFFFFFFFF, 32'h3 << SRC_GP5_RISE, "pin five fall");
      csic_host_model_inst.clear(OFS_FLAG_A, 32'h3FFF);
      // mix drop reaches set b only: set a is masked for it
      csic_host_model_inst.wr(OFS_MASK_A, 32'h00000010);
      csic_host_model_inst.wr(OFS_MASK_B, 32'h00003FEF);
      MIX_DROP <= 1'b1;
      settle(10);
      rdc(OFS_FLAG_A, 32'hFFFFFFFF, 32'h0, "masked flag a");
      rdc(OFS_FLAG_B, 32'hFFFFFFFF, 32'h10, "flag b set");
      check("request a masked", REQ_A, 1'b1);
      check("request b set", REQ_B, 1'b1);
      rdc(OFS_REQSTATE, 32'hFFFFFFFF, 32'h2, "request state b");
      csic_host_model_inst.wr(OFS_CTRL, 32'h00000408);
      rdc(OFS_REQSTATE, 32'hFFFFFFFF, 32'h0, "request state masked");
      csic_host_model_inst.wr(OFS_CTRL, 32'h00000000);
      csic_host_model_inst.wr(OFS_MASK_A, 32'h00000000);
      MIX_DROP <= 1'b0;
      settle(10);
      rdc(OFS_FLAG_A, 32'hFFFFFFFF, 32'h10, "flag a mix fall");
      check("request a active high", REQ_A, 1'b1);
      complete_run;
   end
endmodule // tb
